// file: logic/gpio_irq_if.sv
// carries one port's pin levels and interrupt setup to its detector
// assumes the controller drives the inputs and reads back the matches
`timescale 1ns/100ps
interface gpio_irq_if #(parameter int W = 32);
   logic [W-1:0] level;
   logic [W-1:0] edge_mode;
   logic [W-1:0] pol;
   logic [W-1:0] grp_en;
   logic [W-1:0] grp_pol;
   logic [W-1:0] event_hit;
   logic grp_any;
   logic grp_all;
   modport ctrl (output level, edge_mode, pol, grp_en, grp_pol,
                 input event_hit, grp_any, grp_all);
   modport detect (input level, edge_mode, pol, grp_en, grp_pol,
                   output event_hit, grp_any, grp_all);
endinterface : gpio_irq_if

// file: logic/gpio_pin_irq.sv
// edge or level detector and group matcher for one port
// assumes levels are already synchronous to mclk
`timescale 1ns/100ps
module gpio_pin_irq #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // setup and results
   gpio_irq_if.detect bus
);
   logic [W-1:0] prev;
   logic [W-1:0] active;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prev <= '0;
      end else begin
         prev <= bus.level;
      end
   end

   // active means level equals the chosen polarity
   assign active = ~(bus.level ^ bus.pol);

   assign bus.event_hit = (bus.edge_mode & active & (prev ^ bus.level))
                          | (~bus.edge_mode & active);

   assign bus.grp_any = |(bus.grp_en & ~(bus.level ^ bus.grp_pol));
   assign bus.grp_all = &(~bus.grp_en | ~(bus.level ^ bus.grp_pol));
endmodule : gpio_pin_irq

// file: logic/gpio_pkg.sv
// constants shared by the port block, its property checks and its testbench
// assumes a 32-bit apb slave with a 12-bit byte address
package gpio_pkg;
   localparam int NUM_PORTS = 2;
   localparam int PORT_W = 32;
   localparam int ADDR_W = 12;
   // byte address layout: bit 6 picks the port, bits 5..0 the register
   localparam int PORT_SEL_BIT = 6;
   localparam int OFS_MSB = 5;
   localparam int BANK_LSB = 7;
   localparam logic [4:0] BANK_PORTS = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_GRP_CTRL = 12'h080;
   localparam logic [5:0] OFS_DIR = 6'h00;
   localparam logic [5:0] OFS_MASK = 6'h04;
   localparam logic [5:0] OFS_PIN = 6'h08;
   localparam logic [5:0] OFS_MPIN = 6'h0C;
   localparam logic [5:0] OFS_SET = 6'h10;
   localparam logic [5:0] OFS_CLR = 6'h14;
   localparam logic [5:0] OFS_TGL = 6'h18;
   localparam logic [5:0] OFS_OUT = 6'h1C;
   localparam logic [5:0] OFS_INT_EN = 6'h20;
   localparam logic [5:0] OFS_INT_EDGE = 6'h24;
   localparam logic [5:0] OFS_INT_POL = 6'h28;
   localparam logic [5:0] OFS_INT_STAT = 6'h2C;
   localparam logic [5:0] OFS_GRP_EN = 6'h30;
   localparam logic [5:0] OFS_GRP_POL = 6'h34;
   localparam logic [5:0] OFS_WAKE_EN = 6'h38;
   // group control word fields
   localparam int GRP_AND_BIT = 0;
   localparam int GRP_STAT_BIT = 1;
   localparam logic [PORT_W-1:0] RST_WORD = 32'h00000000;
   localparam logic [PORT_W-1:0] ALL_ONES = 32'hFFFFFFFF;
endpackage : gpio_pkg

// file: logic/gpio_port_block.sv
// two-port general purpose i/o block with apb registers and interrupts
// assumes apb4 master on mclk and pins wired through external pads
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module gpio_port_block
   import gpio_pkg::*;
#(
   parameter int P0_WIDTH = 32,
   parameter int P1_WIDTH = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [PORT_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [PORT_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic [P0_WIDTH+P1_WIDTH-1:0] pin_in,
   output logic [P0_WIDTH+P1_WIDTH-1:0] pin_out,
   output logic [P0_WIDTH+P1_WIDTH-1:0] pin_oe_n,
   // peripheral function ownership
   input wire logic [P0_WIDTH+P1_WIDTH-1:0] periph_sel,
   input wire logic [P0_WIDTH+P1_WIDTH-1:0] periph_out,
   input wire logic [P0_WIDTH+P1_WIDTH-1:0] periph_oe_n,
   // requests
   output logic irq,
   output logic irq_group,
   output logic wake_req
);
   localparam int NPINS = P0_WIDTH + P1_WIDTH;
   localparam logic [PORT_W-1:0] VALID0 = ALL_ONES >> (PORT_W - P0_WIDTH);
   localparam logic [PORT_W-1:0] VALID1 = ALL_ONES >> (PORT_W - P1_WIDTH);

   logic [NPINS-1:0] pin_sync;
   logic [PORT_W-1:0] lvl [NUM_PORTS];
   logic [PORT_W-1:0] dir [NUM_PORTS];
   logic [PORT_W-1:0] mask [NUM_PORTS];
   logic [PORT_W-1:0] outv [NUM_PORTS];
   logic [PORT_W-1:0] int_en [NUM_PORTS];
   logic [PORT_W-1:0] int_edge [NUM_PORTS];
   logic [PORT_W-1:0] int_pol [NUM_PORTS];
   logic [PORT_W-1:0] int_stat [NUM_PORTS];
   logic [PORT_W-1:0] grp_en [NUM_PORTS];
   logic [PORT_W-1:0] grp_pol [NUM_PORTS];
   logic [PORT_W-1:0] wake_en [NUM_PORTS];
   logic [PORT_W-1:0] hit [NUM_PORTS];
   logic [NUM_PORTS-1:0] any_hit;
   logic [NUM_PORTS-1:0] all_hit;
   logic grp_and;
   logic grp_stat;

   logic wr_stb;
   logic rd_stb;
   logic in_ports;
   logic is_grp;
   logic addr_ok;
   logic sel_port;
   logic [5:0] ofs;
   logic [PORT_W-1:0] lanes;

   function automatic logic [PORT_W-1:0] lane_mask(input logic [3:0] strb);
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
   endfunction : lane_mask

   function automatic logic [PORT_W-1:0] merge(input logic [PORT_W-1:0] old,
                                               input logic [PORT_W-1:0] nv,
                                               input logic [PORT_W-1:0] m);
      merge = (old & ~m) | (nv & m);
   endfunction : merge

   function automatic logic [PORT_W-1:0] valid_bits(input logic p);
      valid_bits = p ? VALID1 : VALID0;
   endfunction : valid_bits

   gpio_sync #(.W(NPINS)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .raw(pin_in),
      .synced(pin_sync)
   );

   assign lvl[0] = PORT_W'(pin_sync[P0_WIDTH-1:0]);
   assign lvl[1] = PORT_W'(pin_sync[NPINS-1:P0_WIDTH]);

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      gpio_irq_if #(.W(PORT_W)) ibus ();
      assign ibus.level = lvl[p];
      assign ibus.edge_mode = int_edge[p];
      assign ibus.pol = int_pol[p];
      assign ibus.grp_en = grp_en[p];
      assign ibus.grp_pol = grp_pol[p];
      assign hit[p] = ibus.event_hit & valid_bits(1'(p));
      assign any_hit[p] = ibus.grp_any;
      assign all_hit[p] = ibus.grp_all;
      gpio_pin_irq #(.W(PORT_W)) u_det (
         .mclk(mclk),
         .rst(rst),
         .bus(ibus.detect)
      );
   end

   assign in_ports = (paddr[ADDR_W-1:BANK_LSB] == BANK_PORTS)
                     && (paddr[OFS_MSB:0] <= OFS_WAKE_EN)
                     && (paddr[1:0] == 2'h0);
   assign is_grp = (paddr == ADDR_GRP_CTRL);
   assign addr_ok = in_ports || is_grp;
   assign sel_port = paddr[PORT_SEL_BIT];
   assign ofs = paddr[OFS_MSB:0];
   assign lanes = lane_mask(pstrb) & valid_bits(sel_port);
   assign wr_stb = psel && penable && pready && pwrite && addr_ok;
   assign rd_stb = psel && penable && !pready;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= rd_stb && !addr_ok;
      end
   end

   // read mux, registered so data stands with pready
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prdata <= RST_WORD;
      end else if (rd_stb) begin
         prdata <= RST_WORD;
         if (pwrite || !addr_ok) begin
            prdata <= RST_WORD;
         end else if (is_grp) begin
            prdata[GRP_AND_BIT] <= grp_and;
            prdata[GRP_STAT_BIT] <= grp_stat;
         end else begin
            case (ofs)
               OFS_DIR: prdata <= dir[sel_port];
               OFS_MASK: prdata <= mask[sel_port];
               OFS_PIN: prdata <= lvl[sel_port];
               OFS_MPIN: prdata <= lvl[sel_port] & mask[sel_port];
               OFS_OUT: prdata <= outv[sel_port];
               OFS_INT_EN: prdata <= int_en[sel_port];
               OFS_INT_EDGE: prdata <= int_edge[sel_port];
               OFS_INT_POL: prdata <= int_pol[sel_port];
               OFS_INT_STAT: prdata <= int_stat[sel_port];
               OFS_GRP_EN: prdata <= grp_en[sel_port];
               OFS_GRP_POL: prdata <= grp_pol[sel_port];
               OFS_WAKE_EN: prdata <= wake_en[sel_port];
               default: prdata <= RST_WORD;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            dir[p] <= RST_WORD;
         end
      end else if (wr_stb && in_ports && ofs == OFS_DIR) begin
         dir[sel_port] <= merge(dir[sel_port], pwdata, lanes);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            mask[p] <= RST_WORD;
         end
      end else if (wr_stb && in_ports && ofs == OFS_MASK) begin
         mask[sel_port] <= merge(mask[sel_port], pwdata, lanes);
      end
   end

   // output value register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            outv[p] <= RST_WORD;
         end
      end else if (wr_stb && in_ports) begin
         case (ofs)
            OFS_PIN, OFS_OUT: outv[sel_port] <= merge(outv[sel_port], pwdata, lanes);
            OFS_MPIN: outv[sel_port] <= merge(outv[sel_port], pwdata,
                                               lanes & mask[sel_port]);
            OFS_SET: outv[sel_port] <= outv[sel_port] | (pwdata & lanes);
            OFS_CLR: outv[sel_port] <= outv[sel_port] & ~(pwdata & lanes);
            OFS_TGL: outv[sel_port] <= outv[sel_port] ^ (pwdata & lanes);
            default: outv[sel_port] <= outv[sel_port];
         endcase
      end
   end

   // interrupt and wake setup, one register per process
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            int_en[p] <= RST_WORD;
         end
      end else if (wr_stb && in_ports && ofs == OFS_INT_EN) begin
         int_en[sel_port] <= merge(int_en[sel_port], pwdata, lanes);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            int_edge[p] <= RST_WORD;
         end
      end else if (wr_stb && in_ports && ofs == OFS_INT_EDGE) begin
         int_edge[sel_port] <= merge(int_edge[sel_port], pwdata, lanes);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            int_pol[p] <= RST_WORD;
         end
      end else if (wr_stb && in_ports && ofs == OFS_INT_POL) begin
         int_pol[sel_port] <= merge(int_pol[sel_port], pwdata, lanes);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            grp_en[p] <= RST_WORD;
         end
      end else if (wr_stb && in_ports && ofs == OFS_GRP_EN) begin
         grp_en[sel_port] <= merge(grp_en[sel_port], pwdata, lanes);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            grp_pol[p] <= RST_WORD;
         end
      end else if (wr_stb && in_ports && ofs == OFS_GRP_POL) begin
         grp_pol[sel_port] <= merge(grp_pol[sel_port], pwdata, lanes);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            wake_en[p] <= RST_WORD;
         end
      end else if (wr_stb && in_ports && ofs == OFS_WAKE_EN) begin
         wake_en[sel_port] <= merge(wake_en[sel_port], pwdata, lanes);
      end
   end

   // sticky status, set wins over write-one clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            int_stat[p] <= RST_WORD;
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            if (wr_stb && in_ports && ofs == OFS_INT_STAT && sel_port == 1'(p)) begin
               int_stat[p] <= (int_stat[p] & ~(pwdata & lanes)) | hit[p];
            end else begin
               int_stat[p] <= int_stat[p] | hit[p];
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         grp_and <= 1'b0;
      end else if (wr_stb && is_grp && pstrb[0]) begin
         grp_and <= pwdata[GRP_AND_BIT];
      end
   end

   // group status; and-mode needs at least one enabled pin
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         grp_stat <= 1'b0;
      end else begin
         if (grp_and ? (&all_hit && (|grp_en[0] || |grp_en[1])) : |any_hit) begin
            grp_stat <= 1'b1;
         end else if (wr_stb && is_grp && pstrb[0] && pwdata[GRP_STAT_BIT]) begin
            grp_stat <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
         irq_group <= 1'b0;
         wake_req <= 1'b0;
      end else begin
         irq <= |(int_stat[0] & int_en[0]) || |(int_stat[1] & int_en[1]);
         irq_group <= grp_stat;
         // wake only where software enabled it
         wake_req <= |(int_stat[0] & wake_en[0]) || |(int_stat[1] & wake_en[1]);
      end
   end

   // pad drive: peripheral owns its pins, gpio the rest
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_out <= '0;
         pin_oe_n <= '1;
      end else begin
         pin_out <= (periph_sel & periph_out)
                    | (~periph_sel & {outv[1][P1_WIDTH-1:0], outv[0][P0_WIDTH-1:0]});
         pin_oe_n <= (periph_sel & periph_oe_n)
                     | (~periph_sel & ~{dir[1][P1_WIDTH-1:0], dir[0][P0_WIDTH-1:0]});
      end
   end
endmodule : gpio_port_block

// file: logic/gpio_sync.sv
// two-stage synchroniser for the pin inputs
// assumes pins are asynchronous to mclk; only the second stage is read
`timescale 1ns/100ps
module gpio_sync #(
   parameter int W = 48
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // levels
   input wire logic [W-1:0] raw,
   output logic [W-1:0] synced
);
   logic [W-1:0] meta;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         synced <= '0;
      end else begin
         meta <= raw;
         synced <= meta;
      end
   end
endmodule : gpio_sync

// file: testbench/gpio_pad_board.sv
// board side of the pads: block drive, external sources, pull-ups
// assumes pin_oe_n low means the block drives the pad
`timescale 1ns/100ps
module gpio_pad_board #(
   parameter int W = 48
) (
   // block side
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe_n,
   // external sources
   input wire logic [W-1:0] ext_val,
   input wire logic [W-1:0] ext_en,
   // pad level
   output logic [W-1:0] pin_in
);
   // released pads go to the external source if enabled, else the pull-up, never keep the last level
   always_comb begin
      for (int i = 0; i < W; i++) begin
         pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
   end
endmodule : gpio_pad_board

// file: testbench/gpio_port_block_properties.sv
// protocol and pin checks for the gpio port block, bound to its top
// assumes full-word writes only when the write checks are to fire
`timescale 1ns/100ps
module gpio_port_block_properties
   import gpio_pkg::*;
#(
   parameter int P0_WIDTH = 32,
   parameter int P1_WIDTH = 16
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [PORT_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [PORT_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and owners
   input wire logic [P0_WIDTH+P1_WIDTH-1:0] pin_in,
   input wire logic [P0_WIDTH+P1_WIDTH-1:0] pin_out,
   input wire logic [P0_WIDTH+P1_WIDTH-1:0] pin_oe_n,
   input wire logic [P0_WIDTH+P1_WIDTH-1:0] periph_sel,
   input wire logic [P0_WIDTH+P1_WIDTH-1:0] periph_out,
   input wire logic [P0_WIDTH+P1_WIDTH-1:0] periph_oe_n,
   // requests
   input wire logic irq,
   input wire logic irq_group,
   input wire logic wake_req
);
   localparam logic [ADDR_W-1:0] A_DIR = {6'h00, OFS_DIR};
   localparam logic [ADDR_W-1:0] A_PIN = {6'h00, OFS_PIN};
   localparam logic [ADDR_W-1:0] A_SET = {6'h00, OFS_SET};
   localparam logic [ADDR_W-1:0] A_CLR = {6'h00, OFS_CLR};
   localparam logic [ADDR_W-1:0] A_TGL = {6'h00, OFS_TGL};
   logic [P0_WIDTH+P1_WIDTH-1:0] pin_q;
   logic [2:0] calm;
   wire logic [31:0] out0 = pin_out[31:0];
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // pad reads only mean something once the synchroniser has settled
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_q <= '0;
         calm <= 3'h0;
      end else begin
         pin_q <= pin_in;
         calm <= (pin_in != pin_q) ? 3'h0 : ((calm == 3'h7) ? calm : calm + 3'h1);
      end
   end
   sequence s_wr(logic [ADDR_W-1:0] a);
      psel && penable && pready && pwrite && paddr == a && pstrb == 4'hF
         && periph_sel[31:0] == 32'h0;
   endsequence
   a_ready_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_reset_input: assert property ($fell(rst) |-> &pin_oe_n)
      else $error("pad driven after reset");
   a_dir_drive: assert property (s_wr(A_DIR) |-> ##2 pin_oe_n[31:0] == ~$past(pwdata, 2))
      else $error("direction write not on pads");
   a_whole_write: assert property (s_wr(A_PIN) |-> ##2 out0 == $past(pwdata, 2))
      else $error("whole port write lost");
   a_set_bits: assert property (s_wr(A_SET) |-> ##2 out0 == ($past(out0, 2) | $past(pwdata, 2)))
      else $error("set write wrong");
   a_clr_bits: assert property (s_wr(A_CLR) |-> ##2 out0 == ($past(out0, 2) & ~$past(pwdata, 2)))
      else $error("clear write wrong");
   a_tgl_bits: assert property (s_wr(A_TGL) |-> ##2 out0 == ($past(out0, 2) ^ $past(pwdata, 2)))
      else $error("toggle write wrong");
   a_pin_read: assert property (psel && penable && pready && !pwrite && paddr == A_PIN
      && calm == 3'h7 |-> prdata == pin_in[31:0]) else $error("pin read not pad level");
   a_periph_owns: assert property (&periph_sel |=> pin_out == $past(periph_out)
      && pin_oe_n == $past(periph_oe_n)) else $error("peripheral drive not passed");
endmodule : gpio_port_block_properties
bind gpio_port_block gpio_port_block_properties #(.P0_WIDTH(P0_WIDTH), .P1_WIDTH(P1_WIDTH))
   props_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
   .periph_sel(periph_sel), .periph_out(periph_out), .periph_oe_n(periph_oe_n), .irq(irq),
   .irq_group(irq_group), .wake_req(wake_req));

// file: testbench/gpio_port_block_tb.sv
// self-checking bench for the gpio port block over apb
// assumes the pad board model closes the loop from pin_out to pin_in
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module gpio_port_block_tb;
   import gpio_pkg::*;
   localparam int W = 48;
   localparam logic [31:0] B20 = 32'h00100000;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, irq, irq_group, wake_req;
   logic [W-1:0] pin_in, pin_out, pin_oe_n;
   logic [W-1:0] periph_sel = '0, periph_out = '0, periph_oe_n = '1, ext_val = '0, ext_en = '0;
   int bad_count = 0;
   int checked = 0;
   gpio_port_block gpio_port_block_inst (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .periph_sel(periph_sel),
      .periph_out(periph_out), .periph_oe_n(periph_oe_n), .irq(irq),
      .irq_group(irq_group), .wake_req(wake_req));
   gpio_pad_board gpio_pad_board_inst (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
   initial begin
      forever #2 mclk = ~mclk;
   end
   function automatic logic [11:0] ra(input logic p, input logic [5:0] o);
      return {5'h00, p, o};
   endfunction : ra
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
      apb(1'b1, a, d, s);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0, 4'hF);
   endtask : rd
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask : settle
   task automatic pin20(input logic v);
      @(posedge mclk);
      ext_val[20] <= v;
   endtask : pin20
   task automatic t_dir_bits;
      logic [5:0] op [4] = '{OFS_OUT, OFS_SET, OFS_CLR, OFS_TGL};
      logic [31:0] dv [4] = '{32'h0F0F, 32'hF000, 32'h000F, 32'h0FF0};
      logic [31:0] ex [4] = '{32'h0F0F, 32'hFF0F, 32'hFF00, 32'hF0F0};
      `CHK(pin_oe_n, {W{1'b1}})
      wr(ra(0, OFS_DIR), 32'h000000FF);
      wr(ra(0, OFS_PIN), 32'h123456A5);
      settle(6);
      `CHK(pin_oe_n[31:0], 32'hFFFFFF00)
      `CHK(pin_out[31:0], 32'h123456A5)
      rd(ra(0, OFS_PIN));
      `CHK(r, 32'hFFFFFFA5)
      for (int i = 0; i < 4; i++) begin
         wr(ra(0, op[i]), dv[i]);
         rd(ra(0, OFS_OUT));
         `CHK(r, ex[i])
      end
      rd(ra(0, OFS_TGL));
      `CHK(r, 32'h0)
   endtask : t_dir_bits
   task automatic t_mask_bytes;
      wr(ra(0, OFS_OUT), 32'h0);
      wr(ra(0, OFS_MASK), 32'h000000F0);
      wr(ra(0, OFS_MPIN), 32'hFFFFFFFF);
      rd(ra(0, OFS_OUT));
      `CHK(r, 32'h000000F0)
      settle(3);
      rd(ra(0, OFS_MPIN));
      `CHK(r, 32'h000000F0)
      wr(ra(0, OFS_OUT), 32'h12345678, 4'h4);
      wr(ra(0, OFS_OUT), 32'hABCDEF01, 4'h3);
      rd(ra(0, OFS_OUT));
      `CHK(r, 32'h0034EF01)
   endtask : t_mask_bytes
   task automatic t_port1_periph;
      wr(ra(1, OFS_DIR), 32'hFFFFFFFF);
      wr(ra(1, OFS_OUT), 32'hFFFF1234);
      rd(ra(1, OFS_OUT));
      settle(0);
      `CHK({r, pin_out[47:32], pin_oe_n[47:32]}, 64'h00001234_1234_0000)
      @(posedge mclk);
      periph_sel <= '1;
      periph_out <= 48'hA5A5_0000_3C3C;
      periph_oe_n <= '0;
      settle(6);
      `CHK(pin_out, 48'hA5A5_0000_3C3C)
      rd(ra(1, OFS_PIN));
      `CHK(r, 32'h0000A5A5)
      periph_sel <= '0;
      periph_oe_n <= '1;
   endtask : t_port1_periph
   task automatic t_irq_group;
      ext_en[20] <= 1'b1;
      wr(ra(0, OFS_INT_EDGE), B20);
      wr(ra(0, OFS_INT_POL), B20);
      wr(ra(0, OFS_INT_STAT), 32'hFFFFFFFF);
      wr(ra(0, OFS_INT_EN), B20);
      wr(ra(0, OFS_WAKE_EN), B20);
      pin20(1'b1);
      settle(8);
      `CHK({irq, wake_req}, 2'b11)
      wr(ra(0, OFS_INT_STAT), B20);
      wr(ra(0, OFS_INT_EN), 32'h0);
      pin20(1'b0);
      pin20(1'b1);
      settle(8);
      rd(ra(0, OFS_INT_STAT));
      `CHK({irq, r[20]}, 2'b01)
      wr(ra(0, OFS_INT_EDGE), 32'h0);
      wr(ra(0, OFS_INT_EN), B20);
      wr(ra(0, OFS_INT_STAT), B20);
      settle(3);
      `CHK(irq, 1'b1)
      pin20(1'b0);
      wr(ra(0, OFS_GRP_EN), 32'h00300000);
      wr(ra(0, OFS_GRP_POL), 32'h00300000);
      wr(ADDR_GRP_CTRL, 32'h1);
      wr(ADDR_GRP_CTRL, 32'h3);
      settle(6);
      `CHK(irq_group, 1'b0)
      pin20(1'b1);
      settle(8);
      `CHK(irq_group, 1'b1)
      pin20(1'b0);
      wr(ADDR_GRP_CTRL, 32'h2);
      settle(6);
      `CHK(irq_group, 1'b1)
      apb(1'b0, 12'hFFC, 32'h0, 4'hF);
      `CHK({e, r}, 33'h100000000)
   endtask : t_irq_group
   task automatic tally_and_finish;
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      settle(0);
      t_dir_bits();
      t_mask_bytes();
      t_port1_periph();
      t_irq_group();
      tally_and_finish();
   end
endmodule : gpio_port_block_tb
